// >>> rtl/rss_regs.svh
// Purpose: timing counts, indices and reset values of the rail start-up sequencer
// Assumes: 250 MHz system clock, timers count in 1 us ticks
// Notes: definitions only
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// clock and tick divider
`define RSS_CLK_MHZ 250
`define RSS_T_TICK_US 1
`define RSS_TICK_CYC (`RSS_T_TICK_US * `RSS_CLK_MHZ)
`define RSS_TICK_W 8

// times in microseconds
`define RSS_T_KEEPALIVE_US 400
`define RSS_T_HIGH_US 32000
`define RSS_T_CHAIN_US 1000
`define RSS_T_SYSRAIL_US 0
`define RSS_T_AUX_US 1000
`define RSS_T_SUPPLY_US 2000
`define RSS_T_LONGPRESS_US 4000000
`define RSS_T_RESET_US 40000

// timer counter width, in bits
`define RSS_CNT_W 23

// rail indices on the enable and power-good vectors
`define RSS_NUM_RAILS 13
`define RSS_R_KEEPALIVE 0
`define RSS_R_HIGH 1
`define RSS_R_MEMORY 2
`define RSS_R_CORE 3
`define RSS_R_IO 4
`define RSS_R_SYSRAIL 5
`define RSS_R_SUPPLY 6
`define RSS_R_AUX_A 7
`define RSS_R_AUX_B 8
`define RSS_R_ADC 9
`define RSS_R_AUX_C 10
`define RSS_R_AUX_D 11
`define RSS_R_AUX_E 12
`define RSS_NUM_OPT 4

// timer indices: 0..8 follow the rails, then button and reset
`define RSS_NUM_TMR 11
`define RSS_T_BUTTON 9
`define RSS_T_RESET 10

// synchroniser vector layout and reset value
`define RSS_SYNC_W 18
`define RSS_S_LOCKOUT 0
`define RSS_S_WAKE 1
`define RSS_S_HOLD 2
`define RSS_S_ENABLE 3
`define RSS_S_BUTTON_N 4
`define RSS_S_PGOOD 5
`define RSS_SYNC_RST 18'h00010

`endif

// >>> rtl/rss_pkg.sv
// Purpose: types of the rail start-up sequencer
// Assumes: rss_regs.svh included first
// Notes: none
`include "rss_regs.svh"
package rss_pkg;
  typedef logic [`RSS_CNT_W-1:0] rss_cnt_t;
  typedef enum logic [3:0] {
    RSS_IDLE = 4'h1,
    RSS_RUN = 4'h2,
    RSS_LATCH = 4'h4,
    RSS_LONGOFF = 4'h8
  } rss_state_t;
endpackage

// >>> rtl/rss_dly_if.sv
// Purpose: start condition, limit and expiry of one delay timer
// Assumes: rss_pkg compiled first
// Notes: ctl side belongs to the sequencer
`timescale 1ns/1ps
interface rss_dly_if;
  logic go;
  rss_pkg::rss_cnt_t limit;
  logic done;
  modport ctl (output go, output limit, input done);
  modport tmr (input go, input limit, output done);
endinterface

// >>> rtl/rss_delay.sv
// Purpose: delay timer counting ticks while its start condition holds
// Assumes: tick is a one-cycle enable
// Notes: dropping go clears the count at once
`timescale 1ns/1ps
module rss_delay (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  // timer
  rss_dly_if.tmr dl
);
  rss_pkg::rss_cnt_t cnt_r;
  rss_pkg::rss_cnt_t cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = dl.go && (cnt_r >= dl.limit);
    if (!dl.go) begin
      cnt_nxt = '0;
    end else if (tick && (cnt_r < dl.limit)) begin
      cnt_nxt = cnt_r + rss_pkg::rss_cnt_t'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign dl.done = done_r;
endmodule

// >>> rtl/rss_top.sv
// Purpose: rail start-up and shutdown sequencer with pushbutton and processor reset
// Assumes: one power-good input per rail; pins are asynchronous to CLK_SYS
// Notes: rails 9..12 are held off unless the optional request inputs ask for them
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_top #(
  parameter rss_pkg::rss_cnt_t P_KEEPALIVE = rss_pkg::rss_cnt_t'(`RSS_T_KEEPALIVE_US / `RSS_T_TICK_US),
  parameter rss_pkg::rss_cnt_t P_HIGH = rss_pkg::rss_cnt_t'(`RSS_T_HIGH_US / `RSS_T_TICK_US),
  parameter rss_pkg::rss_cnt_t P_CHAIN = rss_pkg::rss_cnt_t'(`RSS_T_CHAIN_US / `RSS_T_TICK_US),
  parameter rss_pkg::rss_cnt_t P_AUX = rss_pkg::rss_cnt_t'(`RSS_T_AUX_US / `RSS_T_TICK_US),
  parameter rss_pkg::rss_cnt_t P_SUPPLY = rss_pkg::rss_cnt_t'(`RSS_T_SUPPLY_US / `RSS_T_TICK_US),
  parameter rss_pkg::rss_cnt_t P_LONGPRESS = rss_pkg::rss_cnt_t'(`RSS_T_LONGPRESS_US / `RSS_T_TICK_US),
  parameter rss_pkg::rss_cnt_t P_RESET = rss_pkg::rss_cnt_t'(`RSS_T_RESET_US / `RSS_T_TICK_US)
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // supply and host pins
  input wire logic INPUT_ABOVE_LOCKOUT,
  input wire logic WAKE_TRIGGER_IN,
  input wire logic POWER_HOLD_IN,
  input wire logic POWER_ENABLE_IN,
  input wire logic PUSHBUTTON_IN_N,
  // regulator feedback and optional requests
  input wire logic [`RSS_NUM_RAILS-1:0] RAIL_PGOOD,
  input wire logic [`RSS_NUM_OPT-1:0] OPT_RAIL_REQ,
  // outputs
  output logic [`RSS_NUM_RAILS-1:0] RAIL_EN,
  output logic PROCESSOR_RESET_OUT_N
);
  // synchronisers: a bit changes once stages two and three agree
  logic [`RSS_SYNC_W-1:0] s1_r, s2_r, s3_r, flt_r;
  logic [`RSS_SYNC_W-1:0] flt_nxt;

  always_comb begin
    flt_nxt = flt_r;
    for (int i = 0; i < `RSS_SYNC_W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        flt_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s1_r <= `RSS_SYNC_RST;
      s2_r <= `RSS_SYNC_RST;
      s3_r <= `RSS_SYNC_RST;
      flt_r <= `RSS_SYNC_RST;
    end else begin
      s1_r <= {RAIL_PGOOD, PUSHBUTTON_IN_N, POWER_ENABLE_IN, POWER_HOLD_IN, WAKE_TRIGGER_IN, INPUT_ABOVE_LOCKOUT};
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  logic lockout_ok, wake, hold, enable, button;
  logic [`RSS_NUM_RAILS-1:0] pg;
  assign lockout_ok = flt_r[`RSS_S_LOCKOUT];
  assign wake = flt_r[`RSS_S_WAKE];
  assign hold = flt_r[`RSS_S_HOLD];
  assign enable = flt_r[`RSS_S_ENABLE];
  assign button = ~flt_r[`RSS_S_BUTTON_N];
  assign pg = flt_r[`RSS_SYNC_W-1:`RSS_S_PGOOD];

  // 1 us tick from the system clock
  logic [`RSS_TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    tick_nxt = (tick_cnt_r == `RSS_TICK_W'(`RSS_TICK_CYC - 1));
    tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + `RSS_TICK_W'(1);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // delay timers
  rss_dly_if dly [`RSS_NUM_TMR] ();
  // expiry flags gathered into a vector so procedural loops never index the interface array
  logic [`RSS_NUM_TMR-1:0] tmr_done;

  genvar g;
  generate
    for (g = 0; g < `RSS_NUM_TMR; g++) begin : g_tmr
      rss_delay u_delay (
        .clk(CLK_SYS),
        .rst(RST),
        .tick(tick_r),
        .dl(dly[g])
      );
      assign tmr_done[g] = dly[g].done;
    end
  endgenerate

  // main group state
  rss_pkg::rss_state_t state_r, state_nxt;
  logic btn_prev_r, btn_prev_nxt;
  logic short_r, short_nxt;
  // a rerun after a long press keeps going without the wake trigger
  logic rerun_r, rerun_nxt;
  logic long_hit, main_on, off_all, release_evt;

  assign long_hit = dly[`RSS_T_BUTTON].done;
  assign release_evt = btn_prev_r & ~button;
  assign main_on = (state_r == rss_pkg::RSS_RUN) || (state_r == rss_pkg::RSS_LATCH);
  assign off_all = (state_r == rss_pkg::RSS_LONGOFF);

  always_comb begin
    state_nxt = state_r;
    rerun_nxt = rerun_r;
    btn_prev_nxt = button;
    short_nxt = release_evt && !long_hit && !off_all;
    case (state_r)
      rss_pkg::RSS_IDLE: begin
        if (wake) begin
          state_nxt = rss_pkg::RSS_RUN;
        end
      end
      rss_pkg::RSS_RUN: begin
        if (pg[`RSS_R_HIGH] && hold) begin
          state_nxt = rss_pkg::RSS_LATCH;
        end else if (!wake && !rerun_r) begin
          state_nxt = rss_pkg::RSS_IDLE;
        end
      end
      rss_pkg::RSS_LATCH: begin
        if (!hold && !wake) begin
          state_nxt = rss_pkg::RSS_IDLE;
        end
      end
      rss_pkg::RSS_LONGOFF: begin
        if (!button) begin
          state_nxt = rss_pkg::RSS_RUN;
          rerun_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = rss_pkg::RSS_IDLE;
      end
    endcase
    if (long_hit && button) begin
      state_nxt = rss_pkg::RSS_LONGOFF;
    end
    if (state_nxt != rss_pkg::RSS_RUN) begin
      rerun_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_r <= rss_pkg::RSS_IDLE;
      btn_prev_r <= 1'b0;
      short_r <= 1'b0;
      rerun_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rerun_r <= rerun_nxt;
      btn_prev_r <= btn_prev_nxt;
      short_r <= short_nxt;
    end
  end

  // timer start conditions; dropping one cancels its pending delay
  assign dly[`RSS_R_KEEPALIVE].go = lockout_ok && !off_all;
  assign dly[`RSS_R_KEEPALIVE].limit = P_KEEPALIVE;
  assign dly[`RSS_R_HIGH].go = main_on;
  assign dly[`RSS_R_HIGH].limit = P_HIGH;
  assign dly[`RSS_R_MEMORY].go = main_on && pg[`RSS_R_HIGH];
  assign dly[`RSS_R_MEMORY].limit = P_CHAIN;
  assign dly[`RSS_R_CORE].go = main_on && pg[`RSS_R_MEMORY];
  assign dly[`RSS_R_CORE].limit = P_CHAIN;
  assign dly[`RSS_R_IO].go = main_on && pg[`RSS_R_CORE];
  assign dly[`RSS_R_IO].limit = P_CHAIN;
  assign dly[`RSS_R_SYSRAIL].go = main_on && pg[`RSS_R_IO];
  assign dly[`RSS_R_SYSRAIL].limit = rss_pkg::rss_cnt_t'(`RSS_T_SYSRAIL_US / `RSS_T_TICK_US);
  assign dly[`RSS_R_SUPPLY].go = main_on && hold && enable;
  assign dly[`RSS_R_SUPPLY].limit = P_SUPPLY;
  assign dly[`RSS_R_AUX_A].go = main_on && pg[`RSS_R_SYSRAIL];
  assign dly[`RSS_R_AUX_A].limit = P_AUX;
  assign dly[`RSS_R_AUX_B].go = main_on && pg[`RSS_R_SUPPLY];
  assign dly[`RSS_R_AUX_B].limit = P_AUX;
  assign dly[`RSS_T_BUTTON].go = button;
  assign dly[`RSS_T_BUTTON].limit = P_LONGPRESS;
  assign dly[`RSS_T_RESET].go = pg[`RSS_R_SYSRAIL] && !short_r && !off_all;
  assign dly[`RSS_T_RESET].limit = P_RESET;

  // registered outputs
  logic [`RSS_NUM_RAILS-1:0] rail_en_r, rail_en_nxt;
  logic rst_out_n_r, rst_out_n_nxt;

  always_comb begin
    rail_en_nxt = '0;
    for (int i = 0; i <= `RSS_R_AUX_B; i++) begin
      rail_en_nxt[i] = tmr_done[i];
    end
    rail_en_nxt[`RSS_R_SUPPLY] = dly[`RSS_R_SUPPLY].done && hold && enable;
    for (int j = 0; j < `RSS_NUM_OPT; j++) begin
      rail_en_nxt[`RSS_R_ADC + j] = OPT_RAIL_REQ[j] && main_on;
    end
    if (off_all) begin
      rail_en_nxt = '0;
    end
    // long-off pulls reset in the same cycle as the rails drop
    rst_out_n_nxt = tmr_done[`RSS_T_RESET] && pg[`RSS_R_SYSRAIL] && !off_all;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rail_en_r <= '0;
      rst_out_n_r <= 1'b0;
    end else begin
      rail_en_r <= rail_en_nxt;
      rst_out_n_r <= rst_out_n_nxt;
    end
  end

  assign RAIL_EN = rail_en_r;
  assign PROCESSOR_RESET_OUT_N = rst_out_n_r;
endmodule

// >>> dv/rss_top_asserts.sv
// Purpose: port timing checks for the rail start-up sequencer
// Assumes: one tick is RSS_TICK_CYC cycles
// Notes: bound to rss_top
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_top_asserts #(
  parameter rss_pkg::rss_cnt_t P_SUPPLY = 2000,
  parameter rss_pkg::rss_cnt_t P_LONGPRESS = 4000000,
  parameter rss_pkg::rss_cnt_t P_RESET = 40000
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // pins
  input wire logic INPUT_ABOVE_LOCKOUT,
  input wire logic WAKE_TRIGGER_IN,
  input wire logic POWER_HOLD_IN,
  input wire logic POWER_ENABLE_IN,
  input wire logic PUSHBUTTON_IN_N,
  input wire logic [`RSS_NUM_RAILS-1:0] RAIL_PGOOD,
  input wire logic [`RSS_NUM_OPT-1:0] OPT_RAIL_REQ,
  // outputs
  input wire logic [`RSS_NUM_RAILS-1:0] RAIL_EN,
  input wire logic PROCESSOR_RESET_OUT_N
);
  localparam int TK = `RSS_TICK_CYC;
  int sup_r;
  int pb_r;
  int pg_r;
  // cycles each cause has stood
  always_ff @(posedge CLK_SYS) begin
    sup_r <= (POWER_HOLD_IN && POWER_ENABLE_IN) ? sup_r + 1 : 0;
    pb_r <= !PUSHBUTTON_IN_N ? pb_r + 1 : 0;
    pg_r <= RAIL_PGOOD[5] ? pg_r + 1 : 0;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_io_up; $rose(RAIL_PGOOD[4]) ##0 RAIL_EN[4]; endsequence
  sequence s_sys_on; ##[1:20] RAIL_EN[5]; endsequence
  property p_rel; $fell(RST) |-> RAIL_EN == '0 && !PROCESSOR_RESET_OUT_N; endproperty
  a_rel: assert property (p_rel) else $error("outputs not cleared by reset");
  property p_keep; $rose(RAIL_EN[0]) |-> $past(INPUT_ABOVE_LOCKOUT, 250); endproperty
  a_keep: assert property (p_keep) else $error("keepalive rail early");
  property p_mem; $rose(RAIL_EN[2]) |-> $past(RAIL_PGOOD[1], 250); endproperty
  a_mem: assert property (p_mem) else $error("memory rail early");
  property p_sys; s_io_up |-> s_sys_on; endproperty
  a_sys: assert property (p_sys) else $error("startup rail late");
  property p_auxb; $rose(RAIL_EN[8]) |-> $past(RAIL_PGOOD[6], 250); endproperty
  a_auxb: assert property (p_auxb) else $error("aux rail b early");
  property p_sup; $rose(RAIL_EN[6]) |-> sup_r >= (P_SUPPLY - 1) * TK; endproperty
  a_sup: assert property (p_sup) else $error("supply rail early");
  property p_supoff; !(POWER_HOLD_IN && POWER_ENABLE_IN) [*8] |-> !RAIL_EN[6]; endproperty
  a_supoff: assert property (p_supoff) else $error("supply rail not dropped");
  property p_long; pb_r >= (P_LONGPRESS + 2) * TK |-> RAIL_EN == '0 && !PROCESSOR_RESET_OUT_N; endproperty
  a_long: assert property (p_long) else $error("long press left outputs on");
  property p_gate; !RAIL_PGOOD[5] [*8] |-> !PROCESSOR_RESET_OUT_N; endproperty
  a_gate: assert property (p_gate) else $error("reset out not gated");
  property p_rdly; $rose(PROCESSOR_RESET_OUT_N) |-> pg_r >= (P_RESET - 1) * TK; endproperty
  a_rdly: assert property (p_rdly) else $error("reset out released early");
  property p_opt; OPT_RAIL_REQ == '0 [*8] |-> RAIL_EN[12:9] == '0; endproperty
  a_opt: assert property (p_opt) else $error("optional rail on unasked");
endmodule
bind rss_top rss_top_asserts #(.P_SUPPLY(P_SUPPLY), .P_LONGPRESS(P_LONGPRESS), .P_RESET(P_RESET)) u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .INPUT_ABOVE_LOCKOUT(INPUT_ABOVE_LOCKOUT), .WAKE_TRIGGER_IN(WAKE_TRIGGER_IN),
  .POWER_HOLD_IN(POWER_HOLD_IN), .POWER_ENABLE_IN(POWER_ENABLE_IN), .PUSHBUTTON_IN_N(PUSHBUTTON_IN_N),
  .RAIL_PGOOD(RAIL_PGOOD), .OPT_RAIL_REQ(OPT_RAIL_REQ), .RAIL_EN(RAIL_EN),
  .PROCESSOR_RESET_OUT_N(PROCESSOR_RESET_OUT_N));

// >>> dv/rss_host_model.sv
// Purpose: regulators and host side of the sequencer
// Assumes: pgood follows enable after a ramp
// Notes: slow selects the long ramp
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_host_model (
  // clock
  input wire logic clk,
  // regulators and host
  input wire logic [`RSS_NUM_RAILS-1:0] rail_en,
  input wire logic hold_req,
  input wire logic slow,
  output logic [`RSS_NUM_RAILS-1:0] rail_pgood,
  output logic power_hold
);
  logic [`RSS_NUM_RAILS-1:0] ramp_r [0:7];
  always_ff @(posedge clk) begin
    ramp_r[0] <= rail_en;
    for (int i = 1; i < 8; i++) begin
      ramp_r[i] <= ramp_r[i-1];
    end
  end
  // a rail drops out of regulation at once when disabled
  assign rail_pgood = (slow ? ramp_r[7] : ramp_r[0]) & rail_en;
  // hold pin is tied to the high supply rail; the host may pull it down
  assign power_hold = rail_pgood[1] & hold_req;
endmodule

// >>> dv/rss_top_tb.sv
// Purpose: self-checking bench of the rail start-up sequencer
// Assumes: short timer parameters, 250 cycles a tick
// Notes: output index 13 is the processor reset
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_top_tb;
  localparam int TK = `RSS_TICK_CYC;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lockout, wake, enable, button_n, hold_req, slow;
  logic [`RSS_NUM_OPT-1:0] opt;
  logic [`RSS_NUM_RAILS-1:0] pgood, en;
  logic hold, rst_n;
  logic [13:0] outs;
  int err_total = 0, checks_done = 0, cyc = 0;
  assign outs = {rst_n, en};
  initial begin
    forever #2 clk = ~clk;
  end
  rss_top #(.P_KEEPALIVE(2), .P_HIGH(3), .P_CHAIN(2), .P_AUX(2), .P_SUPPLY(3), .P_LONGPRESS(6), .P_RESET(3)) uut (
    .CLK_SYS(clk), .RST(rst), .INPUT_ABOVE_LOCKOUT(lockout), .WAKE_TRIGGER_IN(wake), .POWER_HOLD_IN(hold),
    .POWER_ENABLE_IN(enable), .PUSHBUTTON_IN_N(button_n), .RAIL_PGOOD(pgood), .OPT_RAIL_REQ(opt),
    .RAIL_EN(en), .PROCESSOR_RESET_OUT_N(rst_n));
  rss_host_model host (.clk(clk), .rail_en(en), .hold_req(hold_req), .slow(slow), .rail_pgood(pgood),
    .power_hold(hold));
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_time(input string nm, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("Error %s expected %0d..%0d cycles seen %0d", nm, lo, hi, got);
    end
  endtask
  // waits for an output to reach v; tk is the expected delay in ticks
  task automatic wait_out(input string nm, input int idx, input logic v, input int tk);
    int n = 0;
    while (outs[idx] !== v && n <= (tk + 1) * TK + 40) begin
      @(negedge clk);
      n++;
    end
    chk_time(nm, (tk > 0) ? (tk - 1) * TK : 0, (tk + 1) * TK + 40, n);
  endtask
  task automatic t_boot();
    @(posedge clk) lockout <= 1'b1;
    wait_out("keepalive", 0, 1'b1, 2);
    @(posedge clk) wake <= 1'b1;
    repeat (100) @(posedge clk);
    wake <= 1'b0;
    repeat (1000) @(negedge clk);
    chk_bit("high idle", 1'b0, en[1]);
  endtask
  task automatic t_main();
    @(posedge clk) wake <= 1'b1;
    wait_out("high", 1, 1'b1, 3);
    wait_out("memory", 2, 1'b1, 2);
    wait_out("core", 3, 1'b1, 2);
    wait_out("io", 4, 1'b1, 2);
    wait_out("sysrail", 5, 1'b1, 0);
    wait_out("reset out", 13, 1'b1, 3);
    chk_bit("aux a", 1'b1, en[7]);
    chk_bit("adc off", 1'b0, en[9]);
    @(posedge clk) enable <= 1'b1;
    wait_out("supply", 6, 1'b1, 3);
    wait_out("aux b", 8, 1'b1, 2);
  endtask
  task automatic t_latch();
    @(posedge clk) wake <= 1'b0;
    repeat (50) @(negedge clk);
    chk_bit("latched", 1'b1, &en[5:1]);
    @(posedge clk) enable <= 1'b0;
    wait_out("supply off", 6, 1'b0, 0);
    @(posedge clk) enable <= 1'b1;
    wait_out("supply again", 6, 1'b1, 3);
    @(posedge clk) opt <= 4'hF;
    wait_out("aux e", 12, 1'b1, 0);
  endtask
  task automatic t_short();
    @(posedge clk) button_n <= 1'b0;
    repeat (100) @(posedge clk);
    button_n <= 1'b1;
    wait_out("short press", 13, 1'b0, 0);
    chk_bit("rails kept", 1'b1, en[6]);
    wait_out("reset release", 13, 1'b1, 3);
  endtask
  task automatic t_long();
    @(posedge clk) button_n <= 1'b0;
    slow <= 1'b1;
    wait_out("long press", 1, 1'b0, 6);
    chk_bit("keepalive off", 1'b0, en[0]);
    chk_bit("reset low", 1'b0, rst_n);
    repeat (800) @(posedge clk);
    button_n <= 1'b1;
    wait_out("rerun high", 1, 1'b1, 3);
    chk_bit("rerun keepalive", 1'b1, en[0]);
    wait_out("rerun chain", 5, 1'b1, 6);
    wait_out("rerun reset", 13, 1'b1, 3);
    @(posedge clk) hold_req <= 1'b0;
    wait_out("hold off", 1, 1'b0, 0);
    chk_bit("supply dropped", 1'b0, en[6]);
    wait_out("reset gated", 13, 1'b0, 0);
    @(posedge clk) lockout <= 1'b0;
    wait_out("keepalive drop", 0, 1'b0, 0);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    lockout <= 1'b0;
    wake <= 1'b0;
    enable <= 1'b0;
    button_n <= 1'b1;
    hold_req <= 1'b1;
    slow <= 1'b0;
    opt <= '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_boot();
    t_main();
    t_latch();
    t_short();
    t_long();
    end_of_test();
  end
endmodule
